/* File: core/spmp_pkg.sv */
// constants, states and decode helpers of the serial peripheral port
package spmp_pkg;
	localparam logic [7:0] IDX_CTL1     = 8'hf1;
	localparam logic [7:0] IDX_CTL2     = 8'hf2;
	localparam logic [7:0] IDX_TXB      = 8'hf3;
	localparam logic [7:0] IDX_RXB      = 8'hf4;
	localparam logic [7:0] IDX_STAT     = 8'hf5;
	localparam logic [7:0] RST_CTL1     = 8'h08;
	localparam logic [7:0] RST_CTL2     = 8'h00;
	localparam logic [7:0] RST_TXB      = 8'h00;
	localparam logic [7:0] RST_RXB      = 8'h00;
	localparam logic [7:0] RST_STAT     = 8'h40;
	localparam logic [7:0] CTL2_MASK    = 8'hf7;
	localparam logic [7:0] CTL2_FD_ONLY = 8'h80;
	localparam int C1_EN      = 7;
	localparam int C1_ROLE    = 6;
	localparam int C1_SSPOL   = 5;
	localparam int C1_IDLE    = 4;
	localparam int C1_EDGE    = 3;
	localparam int C1_RATE_LO = 0;
	localparam int C2_FD      = 7;
	localparam int C2_TBC_LO  = 4;
	localparam int C2_RBC_LO  = 0;
	localparam int ST_ORDER   = 6;
	localparam int ST_OV      = 5;
	localparam int ST_TXIF    = 4;
	localparam int ST_TDR     = 3;
	localparam int ST_RXIF    = 2;
	localparam int ST_RDR     = 1;
	localparam int ST_RS      = 0;
	localparam int HALF_BASE  = 2;
	localparam int DIV_W      = 9;
	localparam logic [3:0] FULL_BITS = 4'h8;

	typedef enum logic [1:0] {
		SPMP_IDLE   = 2'b00,
		SPMP_SHIFT  = 2'b01,
		SPMP_FINISH = 2'b11
	} spmp_state_e;

	// bit-count code to number of bits, zero meaning eight
	function automatic logic [3:0] spmp_bits(input logic [2:0] code);
		return (code == 3'h0) ? FULL_BITS : {1'b0, code};
	endfunction
endpackage

/* File: core/spmp_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module spmp_sync #(
	parameter int W = 4
) (
	input  wire logic         ref_clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] q_ff;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			meta_ff <= '0;
			q_ff    <= '0;
		end else begin
			meta_ff <= d;
			q_ff    <= meta_ff;
		end
	end

	assign q = q_ff;
endmodule // spmp_sync

/* File: core/spmp_rate_gen.sv */
// master serial clock half-period tick generator
`timescale 1ns/10ps
module spmp_rate_gen
	import spmp_pkg::*;
#(
	parameter int CW = DIV_W
) (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       run,
	input  wire logic [2:0] code,
	output logic            tick
);
	logic [CW-1:0] cnt_ff;
	logic          tick_ff;

	// half period is two times two to the code
	wire [CW-1:0] half_m1 = CW'((HALF_BASE << code) - 1);
	wire          hit     = (cnt_ff == half_m1);

	always_ff @(posedge ref_clk) begin
		if (rst || !run) begin
			cnt_ff  <= '0;
			tick_ff <= 1'b0;
		end else begin
			cnt_ff  <= hit ? '0 : cnt_ff + 1'b1;
			tick_ff <= hit;
		end
	end

	assign tick = tick_ff;
endmodule // spmp_rate_gen

/* File: core/spmp_top.sv */
// serial peripheral port: registers, shift engine and pin drivers
`timescale 1ns/10ps
// Contract
// - port works only while module enabled
// - role bit picks master or slave
// - select polarity bit sets slave select level
// - idle level bit sets clock between transfers
// - sample edge bit picks latching edge
// - data changes on the non-sampling edge
// - master clock is oscillator over four times power
// - full duplex forces both counts zero
// - full duplex shifts both lines together
// - transmit count sets bits out, zero eight
// - receive count sets bits in, zero eight
// - order bit picks msb or lsb first
// - word over pending word sets overflow
// - transmit flag set on shift register load
// - transmit starts only after ready bit set
// - hardware clears transmit ready on load
// - receive flag set when buffer loaded
// - receive ready set until software clears
// - new word replaces unread receive buffer
// - receive start bit shifts word in
// - data line directions follow the role
// - slave active only while selected
// - all flags share one interrupt request; the code drives it from the transmit and receive flags only
module spmp_top
	import spmp_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [9:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        sck_i,
	output logic             sck_o,
	output logic             sck_oe,
	input  wire logic        mosi_i,
	output logic             mosi_o,
	output logic             mosi_oe,
	input  wire logic        miso_i,
	output logic             miso_o,
	output logic             miso_oe,
	input  wire logic        ss_i,
	output logic             irq_o
);
	logic [7:0]  ctl1_ff;
	logic [7:0]  ctl2_ff;
	logic [7:0]  txb_ff;
	logic [7:0]  rxb_ff;
	logic        order_ff;
	logic        ov_ff;
	logic        txif_ff;
	logic        tdr_ff;
	logic        rxif_ff;
	logic        rdr_ff;
	logic        rs_ff;
	logic        ack_ff;
	logic [31:0] rdat_ff;
	spmp_state_e st_ff;
	spmp_state_e nxt_st;
	logic [7:0]  txsh_ff;
	logic [7:0]  rxsh_ff;
	logic [3:0]  len_ff;
	logic [3:0]  bitc_ff;
	logic [4:0]  tog_ff;
	logic        dorx_ff;
	logic        sampled_ff;
	logic        sck_ff;
	logic        sck_d_ff;
	logic        dout_ff;
	logic        sck_oe_ff;
	logic        mosi_oe_ff;
	logic        miso_oe_ff;
	logic        irq_ff;
	logic [3:0]  pins_s;
	logic        tick;

	// bus decode
	wire       bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
	wire [7:0] idx     = wb_adr_i[9:2];
	wire [7:0] wdat    = wb_dat_i[7:0];
	wire       wr      = bus_req & wb_we_i & wb_sel_i[0];
	wire       wr_c1   = wr & (idx == IDX_CTL1);
	wire       wr_c2   = wr & (idx == IDX_CTL2);
	wire       wr_tx   = wr & (idx == IDX_TXB);
	wire       wr_st   = wr & (idx == IDX_STAT);

	// pin synchronisers
	spmp_sync #(
		.W(4)
	) u_sync (
		.ref_clk(ref_clk),
		.rst    (rst),
		.d      ({sck_i, ss_i, mosi_i, miso_i}),
		.q      (pins_s)
	);
	wire s_sck  = pins_s[3];
	wire s_ss   = pins_s[2];
	wire s_mosi = pins_s[1];
	wire s_miso = pins_s[0];

	// control fields
	wire       en     = ctl1_ff[C1_EN];
	wire       role   = ctl1_ff[C1_ROLE];
	wire       sspol  = ctl1_ff[C1_SSPOL];
	wire       idle   = ctl1_ff[C1_IDLE];
	wire       edge_r = ctl1_ff[C1_EDGE];
	wire [2:0] rate   = ctl1_ff[C1_RATE_LO +: 3];
	wire       fd     = ctl2_ff[C2_FD];
	wire [3:0] txn    = spmp_bits(ctl2_ff[C2_TBC_LO +: 3]);
	wire [3:0] rxn    = spmp_bits(ctl2_ff[C2_RBC_LO +: 3]);
	wire       msb    = order_ff;

	wire master   = en & role;
	wire selected = en & ~role & (s_ss == sspol);
	wire in_shift = (st_ff == SPMP_SHIFT);
	wire run      = master & in_shift;

	spmp_rate_gen #(
		.CW(DIV_W)
	) u_rate (
		.ref_clk(ref_clk),
		.rst    (rst),
		.run    (run),
		.code   (rate),
		.tick   (tick)
	);

	// slave edges come from the synchronised external clock
	wire s_rise = s_sck & ~sck_d_ff;
	wire s_fall = ~s_sck & sck_d_ff;
	wire m_rise = tick & ~sck_ff;
	wire m_fall = tick & sck_ff;
	// slave edges count only while selected
	wire rise   = role ? (run & m_rise) : (selected & s_rise);
	wire fall   = role ? (run & m_fall) : (selected & s_fall);
	wire smp_edge = in_shift & (edge_r ? rise : fall);
	// drive on the other edge once a bit was sampled
	wire drv_edge = in_shift & (edge_r ? fall : rise) & sampled_ff;
	// master listens on miso, slave on mosi
	wire din      = role ? s_miso : s_mosi;

	// a transfer needs transmit ready or receive start
	wire       start   = (st_ff == SPMP_IDLE) & en & (tdr_ff | rs_ff) & (master | ~role);
	wire       load_tx = start & tdr_ff;
	// full duplex always moves eight bits
	wire [3:0] load_n  = fd ? FULL_BITS : (tdr_ff ? txn : rxn);
	// msb first sends the low bits of the buffer top down
	wire [7:0] tx_al   = msb ? (txb_ff << (FULL_BITS - load_n)) : txb_ff;
	wire [7:0] tx_sh   = msb ? {txsh_ff[6:0], 1'b0} : {1'b0, txsh_ff[7:1]};
	wire       tx_nbit = msb ? txsh_ff[6] : txsh_ff[1];
	wire       tx_fbit = msb ? tx_al[7] : tx_al[0];
	wire [7:0] rx_sh   = msb ? {rxsh_ff[6:0], din} : {din, rxsh_ff[7:1]};
	wire [7:0] rx_al   = msb ? rxsh_ff : (rxsh_ff >> (FULL_BITS - len_ff));
	wire       m_end   = run & tick & (tog_ff == ({len_ff, 1'b0} - 5'h1));
	wire       s_end   = ~role & smp_edge & (bitc_ff == (len_ff - 4'h1));
	wire       x_end   = in_shift & (m_end | s_end);
	wire       store   = (st_ff == SPMP_FINISH) & dorx_ff;

	// state sequencing
	assign nxt_st = (st_ff == SPMP_IDLE)  ? (start ? SPMP_SHIFT : SPMP_IDLE) :
	                (st_ff == SPMP_SHIFT) ? (!en ? SPMP_IDLE :
	                                        (x_end ? SPMP_FINISH : SPMP_SHIFT)) :
	                SPMP_IDLE;

	// status next values, hardware set wins over software clear
	wire rdr_clr     = wr_st & ~wdat[ST_RDR];
	wire nxt_txif    = load_tx | (txif_ff & ~(wr_st & ~wdat[ST_TXIF]));
	wire nxt_tdr     = load_tx ? 1'b0 : (wr_st ? wdat[ST_TDR] : tdr_ff);
	wire nxt_rxif    = store | (rxif_ff & ~(wr_st & ~wdat[ST_RXIF]));
	// ready stays until software clears it
	wire nxt_rdr     = store | (rdr_ff & ~rdr_clr);
	// word on top of unread word marks overflow
	wire nxt_ov      = (store & rdr_ff) | (ov_ff & ~rdr_clr);
	// receive start consumed when its transfer begins
	wire nxt_rs      = start ? 1'b0 : (wr_st ? wdat[ST_RS] : rs_ff);
	// setting full duplex zeroes both counts
	wire [7:0] nxt_c2 = wdat[C2_FD] ? CTL2_FD_ONLY : (wdat & CTL2_MASK);
	// master clock toggles on ticks, else rests at idle level
	wire nxt_sck     = run ? (tick ? ~sck_ff : sck_ff) : idle;

	wire [7:0] stat_rd = {1'b0, order_ff, ov_ff, txif_ff, tdr_ff, rxif_ff, rdr_ff, rs_ff};
	wire [7:0] rsel    = (idx == IDX_CTL1) ? ctl1_ff :
	                     (idx == IDX_CTL2) ? ctl2_ff :
	                     (idx == IDX_TXB)  ? txb_ff  :
	                     (idx == IDX_RXB)  ? rxb_ff  :
	                     (idx == IDX_STAT) ? stat_rd : 8'h00;

	// bus slave
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ack_ff  <= 1'b0;
			rdat_ff <= 32'h0;
		end else begin
			ack_ff  <= bus_req;
			rdat_ff <= bus_req ? {24'h0, rsel} : rdat_ff;
		end
	end

	// registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ctl1_ff  <= RST_CTL1;
			ctl2_ff  <= RST_CTL2;
			txb_ff   <= RST_TXB;
			order_ff <= RST_STAT[ST_ORDER];
			txif_ff  <= RST_STAT[ST_TXIF];
			tdr_ff   <= RST_STAT[ST_TDR];
			rxif_ff  <= RST_STAT[ST_RXIF];
			rdr_ff   <= RST_STAT[ST_RDR];
			ov_ff    <= RST_STAT[ST_OV];
			rs_ff    <= RST_STAT[ST_RS];
		end else begin
			ctl1_ff  <= wr_c1 ? wdat : ctl1_ff;
			ctl2_ff  <= wr_c2 ? nxt_c2 : ctl2_ff;
			txb_ff   <= wr_tx ? wdat : txb_ff;
			order_ff <= wr_st ? wdat[ST_ORDER] : order_ff;
			txif_ff  <= nxt_txif;
			tdr_ff   <= nxt_tdr;
			rxif_ff  <= nxt_rxif;
			rdr_ff   <= nxt_rdr;
			ov_ff    <= nxt_ov;
			rs_ff    <= nxt_rs;
		end
	end

	// each received word overwrites the buffer
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rxb_ff <= RST_RXB;
		end else begin
			rxb_ff <= store ? rx_al : rxb_ff;
		end
	end

	// one engine shifts out and in on the same clock
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_ff      <= SPMP_IDLE;
			txsh_ff    <= 8'h00;
			rxsh_ff    <= 8'h00;
			len_ff     <= FULL_BITS;
			bitc_ff    <= 4'h0;
			tog_ff     <= 5'h0;
			dorx_ff    <= 1'b0;
			sampled_ff <= 1'b0;
			dout_ff    <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			if (start) begin
				txsh_ff    <= tdr_ff ? tx_al : 8'h00;
				rxsh_ff    <= 8'h00;
				len_ff     <= load_n;
				bitc_ff    <= 4'h0;
				tog_ff     <= 5'h0;
				dorx_ff    <= rs_ff | fd;
				sampled_ff <= 1'b0;
				dout_ff    <= tdr_ff ? tx_fbit : 1'b0;
			end else begin
				rxsh_ff    <= smp_edge ? rx_sh : rxsh_ff;
				bitc_ff    <= smp_edge ? bitc_ff + 4'h1 : bitc_ff;
				tog_ff     <= (run & tick) ? tog_ff + 5'h1 : tog_ff;
				sampled_ff <= smp_edge | (sampled_ff & ~drv_edge);
				txsh_ff    <= drv_edge ? tx_sh : txsh_ff;
				dout_ff    <= drv_edge ? tx_nbit : dout_ff;
			end
		end
	end

	// pin drivers and interrupt
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sck_ff     <= 1'b0;
			sck_d_ff   <= 1'b0;
			sck_oe_ff  <= 1'b0;
			mosi_oe_ff <= 1'b0;
			miso_oe_ff <= 1'b0;
			irq_ff     <= 1'b0;
		end else begin
			sck_ff     <= nxt_sck;
			sck_d_ff   <= s_sck;
			sck_oe_ff  <= master;
			mosi_oe_ff <= master;
			miso_oe_ff <= selected;
			// one shared request for the transmit and receive flags
			irq_ff     <= nxt_txif | nxt_rxif;
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdat_ff;
	assign sck_o    = sck_ff;
	assign sck_oe   = sck_oe_ff;
	assign mosi_o   = dout_ff;
	assign mosi_oe  = mosi_oe_ff;
	assign miso_o   = dout_ff;
	assign miso_oe  = miso_oe_ff;
	assign irq_o    = irq_ff;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	a_disable_idle: assert property (!en |=> st_ff == SPMP_IDLE)
		else $error("port not idle while disabled");
	a_role_clock: assert property (master |=> sck_oe && mosi_oe && !miso_oe)
		else $error("master pin directions wrong");
	a_select_pol: assert property ((en && !role && s_ss != sspol) |=> !miso_oe)
		else $error("unselected slave drives miso");
	a_idle_level: assert property ((master && !in_shift) |=> sck_o == $past(idle))
		else $error("serial clock not at idle level");
	a_bit_count: assert property (x_end |-> (bitc_ff + 4'(smp_edge)) == len_ff)
		else $error("transfer length mismatch");
	a_fd_zero: assert property (fd |-> ctl2_ff[6:4] == 3'h0 && ctl2_ff[2:0] == 3'h0)
		else $error("counts not zero in full duplex");
	a_tx_load: assert property (load_tx |=> txif_ff && !tdr_ff && in_shift)
		else $error("transmit load flags wrong");
	a_rx_store: assert property (store |=> rdr_ff && rxif_ff && rxb_ff == $past(rx_al))
		else $error("receive store wrong");
	a_overflow: assert property ((store && rdr_ff) |=> ov_ff)
		else $error("overflow not flagged");
	a_ready_clear: assert property ((rdr_clr && !store) |=> !rdr_ff && !ov_ff)
		else $error("ready clear missed");
	a_start_cause: assert property ((in_shift && $past(st_ff) == SPMP_IDLE) |->
		$past(tdr_ff || rs_ff))
		else $error("transfer started without request");
	a_shift_end: assert property ((st_ff == SPMP_FINISH) |=> st_ff == SPMP_IDLE)
		else $error("finish state held");
endmodule // spmp_top

/* File: verif/spmp_peer.sv */
// behavioural far-side serial device, slave or master
`timescale 1ns/10ps
module spmp_peer (
	input  wire logic sck,
	input  wire logic sin,
	input  wire logic ss_n,
	input  wire logic rise_smp,
	input  wire logic msb,
	output logic      sout,
	output logic      sck_d
);
	logic [7:0] tx_byte   = 8'h00;
	logic [7:0] rx_bits   = 8'h00;
	int         n_smp     = 0;
	bit         as_master = 1'b0;
	initial sout = 1'b0;
	initial sck_d = 1'b0;
	always @(sck) if (!ss_n && sck === rise_smp) begin
		rx_bits <= {rx_bits[6:0], sin};
		n_smp   <= n_smp + 1;
	end
	always @(sck) if (!as_master && !ss_n && sck === !rise_smp && n_smp inside {[1:7]})
		sout <= tx_byte[msb ? 7 - n_smp : n_smp];
	// select loads first bit, release inverts
	always @(ss_n) if (!ss_n) begin
		n_smp   <= 0;
		rx_bits <= 8'h00;
		sout    <= tx_byte[msb ? 7 : 0];
	end else sout <= ~sout;
	// master role drives the clock, still between frames
	task automatic send(input logic [7:0] b);
		as_master = 1'b1;
		// move off the port's clock edge so pins never change as it samples
		#5;
		for (int i = 0; i < 8; i++) begin
			sout = b[7 - i];
			#100 sck_d = 1'b1;
			#100 sck_d = 1'b0;
		end
		sout = ~sout;
	endtask
endmodule // spmp_peer

/* File: verif/spmp_top_tb_top.sv */
// self-checking bench of the serial peripheral port
`timescale 1ns/10ps
module spmp_top_tb_top;
	import spmp_pkg::*;
	logic        ref_clk = 1'b0;
	logic        rst     = 1'b1;
	logic        cyc     = 1'b0;
	logic        stb     = 1'b0;
	logic        we      = 1'b0;
	logic [9:0]  adr     = '0;
	logic [31:0] wdat    = '0;
	logic        ss_n    = 1'b1;
	logic        rise    = 1'b1;
	logic        msb     = 1'b1;
	logic        slv     = 1'b0;
	logic        sck_prev = 1'b0;
	int          cnt = 0;
	int          half_len = 0;
	int          errors = 0;
	int          n_tests = 0;
	logic [31:0] rdat;
	logic        ack, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, irq, p_out, p_sck;
	logic [7:0]  q, tx, px;
	logic [7:0]  exp_q[$];
	logic [7:0]  rv[5] = '{RST_CTL1, RST_CTL2, RST_TXB, RST_RXB, RST_STAT};
	wire         sck_w  = sck_oe ? sck_o : p_sck;
	wire         mosi_w = mosi_oe ? mosi_o : p_out;
	wire         miso_w = miso_oe ? miso_o : p_out;

	always #12.5 ref_clk = ~ref_clk;

	spmp_top i_spmp_top (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .sck_i(sck_w), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_w),
		.mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_w), .miso_o(miso_o),
		.miso_oe(miso_oe), .ss_i(ss_n), .irq_o(irq));

	spmp_peer i_spmp_peer (.sck(sck_w), .sin(slv ? miso_w : mosi_w), .ss_n(ss_n),
		.rise_smp(rise), .msb(msb), .sout(p_out), .sck_d(p_sck));

	always @(posedge ref_clk) begin
		sck_prev <= sck_o;
		cnt      <= (sck_o !== sck_prev) ? 1 : cnt + 1;
		if (sck_o !== sck_prev) half_len <= cnt;
	end

	task automatic wrap_up;
		$display("tests %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic tmo;
		errors++;
		$display("unexpected at %0t: wait ran out", $time);
		wrap_up();
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] want);
		n_tests++;
		if (got !== want) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, want);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
		int k;
		k = 0;
		@(posedge ref_clk);
		{cyc, stb, we} <= {2'b11, w};
		adr  <= {idx, 2'b00};
		wdat <= {24'h0, d};
		do begin
			@(posedge ref_clk);
			k++;
		end while (ack !== 1'b1 && k < 20);
		q = rdat[7:0];
		{cyc, stb} <= 2'b00;
		if (ack !== 1'b1) tmo();
	endtask
	task automatic sel(input logic v);
		ss_n <= v;
		@(posedge ref_clk);
	endtask
	task automatic wait_bits(input int n, input logic idle);
		int k;
		for (k = 0; k < 4000 && !(i_spmp_peer.n_smp == n && sck_w === idle); k++)
			@(posedge ref_clk);
		if (k == 4000) tmo();
		repeat (4) @(posedge ref_clk);
	endtask
	task automatic wait_rdr;
		int k;
		for (k = 0; k < 600; k++) begin
			bus(0, IDX_STAT, '0);
			if (q[ST_RDR] === 1'b1) break;
		end
		if (k == 600) tmo();
	endtask
	function automatic logic [7:0] m_rx(input logic [7:0] s, input int n, input logic m);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < n; i++)
			if (m) r = {r[6:0], s[7 - i]};
			else r[i] = s[i];
		return r;
	endfunction
	function automatic logic [7:0] m_tx(input logic [7:0] s, input int n, input logic m);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < n; i++) r = {r[6:0], m ? s[n - 1 - i] : s[i]};
		return r;
	endfunction

	initial begin
		void'($urandom(32'h9af3));
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		foreach (rv[i]) begin
			bus(0, IDX_CTL1 + 8'(i), '0);
			chk(q, rv[i]);
		end
		bus(1, 8'h10, 8'hff);
		bus(0, 8'h10, '0);
		chk(q, 8'h00);
		bus(1, IDX_RXB, 8'h5a);
		bus(0, IDX_RXB, '0);
		chk(q, 8'h00);
		bus(1, IDX_CTL2, 8'hff);
		bus(0, IDX_CTL2, '0);
		chk(q, 8'h80);
		$display("registers done");
		for (int m = 0; m < 4; m++) begin
			rise <= m[0];
			bus(1, IDX_CTL1, {2'b11, 1'b0, m[1], m[0], 3'(m + 2)});
			tx = 8'($urandom);
			px = 8'($urandom);
			i_spmp_peer.tx_byte = px;
			sel(0);
			chk(sck_w, m[1]);
			chk({sck_oe, mosi_oe, miso_oe}, 3'b110);
			bus(1, IDX_TXB, tx);
			bus(1, IDX_STAT, 8'h48);
			wait_bits(8, m[1]);
			wait_rdr();
			chk(q, 8'h56);
			chk(irq, 1'b1);
			chk(i_spmp_peer.rx_bits, m_tx(tx, 8, 1'b1));
			bus(0, IDX_RXB, '0);
			chk(q, m_rx(px, 8, 1'b1));
			chk(8'(half_len), 8'(2 << (m + 2)));
			bus(1, IDX_STAT, 8'h40);
			sel(1);
			bus(0, IDX_STAT, '0);
			chk(q, 8'h40);
			chk(irq, 1'b0);
		end
		$display("full duplex modes done");
		msb <= 1'b0;
		rise <= 1'b1;
		bus(1, IDX_CTL1, 8'hca);
		bus(1, IDX_CTL2, 8'h05);
		for (int r = 0; r < 2; r++) begin
			px = 8'($urandom);
			i_spmp_peer.tx_byte = px;
			sel(0);
			// keep receive ready and its flag so the second word overruns
			bus(1, IDX_STAT, 8'h07);
			wait_bits(5, 1'b0);
			wait_rdr();
			exp_q.push_back(m_rx(px, 5, 1'b0));
			sel(1);
		end
		chk(q & 8'hef, 8'h26);
		bus(0, IDX_RXB, '0);
		chk(q, exp_q[$]);
		bus(1, IDX_STAT, 8'h00);
		bus(0, IDX_STAT, '0);
		chk(q, 8'h00);
		$display("receive overrun done");
		bus(1, IDX_CTL2, 8'h30);
		tx = 8'($urandom);
		sel(0);
		bus(1, IDX_TXB, tx);
		repeat (20) @(posedge ref_clk);
		chk(8'(i_spmp_peer.n_smp), 8'h00);
		bus(1, IDX_STAT, 8'h08);
		wait_bits(3, 1'b0);
		chk(i_spmp_peer.rx_bits, m_tx(tx, 3, 1'b0));
		bus(0, IDX_STAT, '0);
		chk(q, 8'h10);
		sel(1);
		sel(0);
		bus(1, IDX_CTL1, 8'h4a);
		bus(1, IDX_STAT, 8'h08);
		repeat (40) @(posedge ref_clk);
		chk(8'(i_spmp_peer.n_smp), 8'h00);
		bus(0, IDX_STAT, '0);
		chk(q & 8'h08, 8'h08);
		bus(1, IDX_STAT, 8'h00);
		sel(1);
		$display("short transmit and disable done");
		{msb, slv} <= 2'b11;
		bus(1, IDX_CTL1, 8'h8f);
		bus(1, IDX_CTL2, 8'h80);
		tx = 8'($urandom);
		px = 8'($urandom);
		bus(1, IDX_TXB, tx);
		bus(1, IDX_STAT, 8'h48);
		chk({sck_oe, mosi_oe, miso_oe}, 3'b000);
		sel(0);
		repeat (4) @(posedge ref_clk);
		chk(miso_oe, 1'b1);
		i_spmp_peer.send(px);
		wait_rdr();
		chk(q, 8'h56);
		bus(0, IDX_RXB, '0);
		chk(q, px);
		chk(i_spmp_peer.rx_bits, tx);
		bus(1, IDX_CTL1, 8'haf);
		repeat (4) @(posedge ref_clk);
		chk(miso_oe, 1'b0);
		sel(1);
		$display("slave role done");
		wrap_up();
	end
endmodule // spmp_top_tb_top
